// ---- verilog/ivam_top.v ----
// reset and interrupt vector address generator for the core's pc load
// assumes the core pulses int_accept_i only while irq_pending_o is high,
// and that fuse, select bit and boot address are steady levels;
// run-time reset sources are requests, and rst_i alone also yields a reset load;
// boot_reset_addr_i carries the boot section start chosen outside this block
`timescale 1ns/100ps
`default_nettype none
`include "ivam_defs.vh"

// How it works
// (R01) Every reset source, pin, power-on, brown-out, watchdog or debug, restarts at word 0.
// (R02) External requests 0, 1 and 2 map to words 2, 4 and 6.
// (R03) Pin-change groups 0 to 3 map to words 8, A, C and E.
// (R04) The watchdog time-out request maps to word 10 as vector nine.
// (R05) Timer 2 match A, match B and overflow map to words 12, 14 and 16.
// (R06) Timer 1 capture, match A, match B and overflow map to words 18, 1A, 1C and 1E.
// (R07) Timer 0 match A, match B and overflow map to words 20, 22 and 24.
// (R08) The serial peripheral transfer-done request maps to word 26 as vector twenty.
// (R09) Serial port 0 receive, transmit-empty and transmit-done map to words 28, 2A and 2C.
// (R10) Comparator, converter, data memory ready, two-wire and store ready map to 2E through 36.
// (R11) Serial port 1 receive, transmit-empty and transmit-done map to words 38, 3A and 3C.
// (R12) A programmed boot-reset fuse sends every reset to the boot loader entry instead of 0.
// (R13) With the select bit set every interrupt vector is offset by the boot section start.
// (R14) Reset address follows the fuse and the vector base follows the select bit, independently.
// (R15) Vector words get no special handling; only an accepted request loads one into the pc.
// (R16) An accepted interrupt loads base plus twice the vector number, less two.
module ivam_top (
    // clock and reset
    input  wire                    clk_i,
    input  wire                    rst_i,
    // reset sources seen while running, one bit per source
    input  wire                    ext_pin_reset_i,
    input  wire                    power_on_reset_i,
    input  wire                    brown_out_reset_i,
    input  wire                    watchdog_reset_i,
    input  wire                    debug_reset_i,
    // placement controls
    input  wire                    boot_reset_fuse_i,
    input  wire                    vector_select_bit_i,
    input  wire [`IVAM_PC_W-1:0]   boot_reset_addr_i,
    // peripheral requests, bit k for vector k+2
    input  wire [`IVAM_IRQ_N-1:0]  irq_req_i,
    // core handshake
    input  wire                    int_accept_i,
    output wire                    irq_pending_o,
    output wire [`IVAM_NUM_W-1:0]  irq_vec_num_o,
    // pc load to the core
    output wire                    pc_load_o,
    output wire                    pc_is_reset_o,
    output wire [`IVAM_PC_W-1:0]   pc_addr_o
);
    // two states: the first edge after release, then running
    localparam ST_RESET = 1'b0;
    localparam ST_RUN   = 1'b1;

    // registers and their next values
    reg                   state_reg;
    reg                   state_next;
    reg                   fuse_reg;
    reg                   fuse_next;
    reg                   pending_reg;
    reg [`IVAM_NUM_W-1:0] num_reg;
    reg                   load_reg;
    reg                   load_next;
    reg                   is_reset_reg;
    reg                   is_reset_next;
    reg [`IVAM_PC_W-1:0]  addr_reg;
    reg [`IVAM_PC_W-1:0]  addr_next;

    // internal nets
    wire                   enc_any;
    wire [`IVAM_NUM_W-1:0] enc_num;
    wire                   any_reset_req;
    wire [`IVAM_PC_W-1:0]  reset_addr;
    wire [`IVAM_PC_W-1:0]  vec_base;
    wire                   take_entry;
    wire [`IVAM_PC_W-1:0]  entry_addr;

    // two words per vector, counted from vector one at the base
    function [`IVAM_PC_W-1:0] vec_addr;
        input [`IVAM_PC_W-1:0]  base;
        input [`IVAM_NUM_W-1:0] num;
        reg   [`IVAM_NUM_W-1:0] idx;
        begin
            idx      = num - `IVAM_RESET_VEC;
            vec_addr = base + {{(`IVAM_PC_W-`IVAM_NUM_W-1){1'b0}}, idx, 1'b0};
        end
    endfunction

    // one place decides the reset entry, for release and for run-time sources
    function [`IVAM_PC_W-1:0] reset_target;
        input                   fuse;
        input [`IVAM_PC_W-1:0]  boot;
        begin
            if (fuse == `IVAM_FUSE_PROG) begin
                reset_target = boot; // [R12]
            end else begin
                reset_target = `IVAM_RESET_ADDR;
            end
        end
    endfunction

    // fixed bit order gives the whole table R02..R11
    ivam_vec_enc u_enc (
        .req_i (irq_req_i),
        .any_o (enc_any),
        .num_o (enc_num)
    );

    // all running reset sources share one entry
    assign any_reset_req = ext_pin_reset_i | power_on_reset_i | brown_out_reset_i
                         | watchdog_reset_i | debug_reset_i; // [R01]

    // fuse value is the one caught after reset release, not the live pin
    assign reset_addr = reset_target(fuse_reg, boot_reset_addr_i); // [R12] [R14]

    // select bit may change at run time, so it is used live
    assign vec_base = vector_select_bit_i ? boot_reset_addr_i
                                          : `IVAM_RESET_ADDR; // [R13] [R14]

    // an accept counts only with a vector pending and no reset source
    assign take_entry = int_accept_i & pending_reg & ~any_reset_req;

    // taken from the registered vector number, so the address always
    // matches what irq_vec_num_o showed at the accept edge
    assign entry_addr = vec_addr(vec_base, num_reg); // [R16]

    // state and fuse capture
    always @* begin
        state_next = state_reg;
        fuse_next  = fuse_reg;
        case (state_reg)
            ST_RESET: begin
                // strap sampled on the first edge after release
                fuse_next  = boot_reset_fuse_i;
                state_next = ST_RUN;
            end
            ST_RUN: begin
                // stays here until rst_i is raised again
                state_next = ST_RUN;
            end
            default: begin
                // unused code falls back to the reset entry
                state_next = ST_RESET;
            end
        endcase
    end

    // pc-load decision: release first, then reset sources, then entries
    always @* begin
        load_next     = 1'b0;
        is_reset_next = 1'b0;
        addr_next     = addr_reg;
        case (state_reg)
            ST_RESET: begin
                // the fuse pin is still live here, fuse_reg catches it now
                load_next     = 1'b1;
                is_reset_next = 1'b1;
                addr_next     = reset_target(boot_reset_fuse_i, boot_reset_addr_i); // [R12]
            end
            ST_RUN: begin
                if (any_reset_req) begin
                    // reset wins over any interrupt entry in the same cycle
                    load_next     = 1'b1;
                    is_reset_next = 1'b1;
                    addr_next     = reset_addr; // [R01]
                end else if (take_entry) begin
                    // only an accepted request touches the pc [R15]
                    load_next = 1'b1;
                    addr_next = entry_addr; // [R16]
                end
            end
            default: begin
                // unused code gives no load
                load_next = 1'b0;
            end
        endcase
    end

    // control state
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= ST_RESET;
            fuse_reg  <= 1'b1;
        end else begin
            state_reg <= state_next;
            fuse_reg  <= fuse_next;
        end
    end

    // pending/num follow the requests one cycle late
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pending_reg <= 1'b0;
            num_reg     <= `IVAM_NO_VEC;
        end else begin
            pending_reg <= enc_any;
            num_reg     <= enc_num; // [R02] [R03] [R04] [R05] [R06] [R07] [R08] [R09] [R10] [R11]
        end
    end

    // pc load pulse, kind and address
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            load_reg     <= 1'b0;
            is_reset_reg <= 1'b0;
            addr_reg     <= `IVAM_RESET_ADDR;
        end else begin
            load_reg     <= load_next;
            is_reset_reg <= is_reset_next;
            addr_reg     <= addr_next;
        end
    end

    // outputs straight from the registers
    assign irq_pending_o = pending_reg;
    assign irq_vec_num_o = num_reg;
    assign pc_load_o     = load_reg;
    assign pc_is_reset_o = is_reset_reg;
    assign pc_addr_o     = addr_reg;
endmodule
`default_nettype wire

// ---- verilog/ivam_defs.vh ----
// constants for the interrupt vector address map
// assumes word-addressed program memory, 17-bit program counter
`ifndef IVAM_DEFS_VH
`define IVAM_DEFS_VH

// widths
`define IVAM_PC_W          17
`define IVAM_NUM_W         5
`define IVAM_IRQ_N         30

// fixed addresses and vector numbers
`define IVAM_RESET_ADDR    17'h00000
`define IVAM_RESET_VEC     5'h01
`define IVAM_FIRST_IRQ_VEC 5'h02
`define IVAM_NO_VEC        5'h00

// fuse polarity (fuse programmed reads as zero)
`define IVAM_FUSE_PROG     1'b0

// request bit positions, bit k serves vector k+2
`define IVAM_B_EXT_IRQ_0        0
`define IVAM_B_EXT_IRQ_1        1
`define IVAM_B_EXT_IRQ_2        2
`define IVAM_B_PIN_CHANGE_IRQ_0 3
`define IVAM_B_PIN_CHANGE_IRQ_3 6
`define IVAM_B_WATCHDOG_TIMEOUT 7
`define IVAM_B_TC2_MATCH_A      8
`define IVAM_B_TC1_CAPTURE      11
`define IVAM_B_TC0_MATCH_A      15
`define IVAM_B_TC0_OVERFLOW     17
`define IVAM_B_SERIAL_PERIPH    18
`define IVAM_B_SERIAL0_RX_DONE  19
`define IVAM_B_ANALOG_COMP      22
`define IVAM_B_PROGRAM_STORE    26
`define IVAM_B_SERIAL1_RX_DONE  27
`define IVAM_B_SERIAL1_TX_DONE  29

`endif

// ---- verilog/ivam_vec_enc.v ----
// request-to-vector encoder: lowest pending bit gives the vector number
// assumes requests are levels synchronous to the core clock
`timescale 1ns/100ps
`default_nettype none
`include "ivam_defs.vh"

module ivam_vec_enc (
    // requests, bit k for vector k+2
    input  wire [`IVAM_IRQ_N-1:0] req_i,
    // encoded result
    output reg                    any_o,
    output reg  [`IVAM_NUM_W-1:0] num_o
);
    integer k;

    // scan from the top so the lowest index is written last and wins
    always @* begin
        any_o = 1'b0;
        num_o = `IVAM_NO_VEC;
        for (k = `IVAM_IRQ_N - 1; k >= 0; k = k - 1) begin
            if (req_i[k]) begin
                any_o = 1'b1;
                num_o = k[`IVAM_NUM_W-1:0] + `IVAM_FIRST_IRQ_VEC;
            end
        end
    end
endmodule
`default_nettype wire

// ---- bench/ivam_core_model.sv ----
// core-side model: takes the pending vector when allowed
// assumes it shares clock and reset with ivam_top
`timescale 1ns/100ps
`default_nettype none
module ivam_core_model (
    // clock, reset and handshake
    input  wire logic clk_i, rst_i, go_i, irq_pending_i,
    output var  logic int_accept_o
);
    // one-cycle pulse, never raised without a pending vector
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) int_accept_o <= 1'h0;
        else int_accept_o <= go_i & irq_pending_i & ~int_accept_o;
    end
endmodule
`default_nettype wire

// ---- bench/ivam_checker.sv ----
// assertions on the vector address generator ports
// assumes it is bound onto ivam_top
`timescale 1ns/100ps
`default_nettype none
`include "ivam_defs.vh"
module ivam_checker (
    // every port of the generator
    input wire logic clk_i, rst_i, ext_pin_reset_i, power_on_reset_i, brown_out_reset_i,
    input wire logic watchdog_reset_i, debug_reset_i, boot_reset_fuse_i, vector_select_bit_i,
    input wire logic int_accept_i, irq_pending_o, pc_load_o, pc_is_reset_o,
    input wire logic [`IVAM_PC_W-1:0]  boot_reset_addr_i, pc_addr_o,
    input wire logic [`IVAM_IRQ_N-1:0] irq_req_i,
    input wire logic [`IVAM_NUM_W-1:0] irq_vec_num_o
);
    wire any_rst = ext_pin_reset_i | power_on_reset_i | brown_out_reset_i
                 | watchdog_reset_i | debug_reset_i;
    logic run_reg; // low on the first edge, where the reset load is due
    always_ff @(posedge clk_i or posedge rst_i) run_reg <= ~rst_i;
    logic fuse_seen; // fuse as caught on the first edge after release
    always_ff @(posedge clk_i or posedge rst_i)
        if (rst_i) fuse_seen <= 1'b1;
        else if (!run_reg) fuse_seen <= boot_reset_fuse_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take; irq_pending_o && int_accept_i && !any_rst; endsequence
    chk_int_load: assert property (s_take |=> pc_load_o && !pc_is_reset_o)
        else $error("interrupt entry gave no pc load");
    chk_int_addr: assert property (s_take |=> pc_addr_o == ($past(vector_select_bit_i) ?
        $past(boot_reset_addr_i) : 17'h00000) + {11'h000, $past(irq_vec_num_o) - 5'h01, 1'h0})
        else $error("interrupt entry address wrong");
    chk_rst_load: assert property (any_rst |=> pc_load_o && pc_is_reset_o)
        else $error("reset source gave no reset load");
    chk_first_load: assert property (!run_reg |=> pc_load_o && pc_is_reset_o)
        else $error("no reset load after release");
    chk_rst_addr: assert property (pc_load_o && pc_is_reset_o |->
        pc_addr_o == (fuse_seen ? 17'h00000 : boot_reset_addr_i))
        else $error("reset load address wrong");
    chk_no_load: assert property (run_reg && !any_rst && !(int_accept_i && irq_pending_o)
        |=> !pc_load_o) else $error("pc load without cause");
    chk_pend_none: assert property (!(|irq_req_i) |=> !irq_pending_o && irq_vec_num_o == 5'h00)
        else $error("pending without request");
    chk_first_vec: assert property (irq_req_i[0] |=> irq_pending_o && irq_vec_num_o == 5'h02)
        else $error("first request not vector two");
    chk_last_vec: assert property (irq_req_i == 30'h20000000 |=> irq_vec_num_o == 5'h1F)
        else $error("last request not vector 31");
endmodule
bind ivam_top ivam_checker chk_u (.clk_i(clk_i), .rst_i(rst_i), .ext_pin_reset_i(ext_pin_reset_i),
    .power_on_reset_i(power_on_reset_i), .brown_out_reset_i(brown_out_reset_i),
    .watchdog_reset_i(watchdog_reset_i), .debug_reset_i(debug_reset_i),
    .boot_reset_fuse_i(boot_reset_fuse_i), .vector_select_bit_i(vector_select_bit_i),
    .int_accept_i(int_accept_i), .irq_pending_o(irq_pending_o), .pc_load_o(pc_load_o),
    .pc_is_reset_o(pc_is_reset_o), .boot_reset_addr_i(boot_reset_addr_i), .pc_addr_o(pc_addr_o),
    .irq_req_i(irq_req_i), .irq_vec_num_o(irq_vec_num_o));
`default_nettype wire

// ---- bench/testbench.sv ----
// self-checking bench for the vector address generator
// assumes the core model drives the accept pulse
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [16:0] BOOT_ADDR = 17'h1F000; // plain default section start
    localparam logic [16:0] BOOT_ALT = 17'h0F800; // other start, used from the mid-run reset
    typedef struct packed { logic [4:0] b; logic [16:0] a; } ivam_row_t;
    ivam_row_t rows [30] = '{'{0, 17'h00002}, '{1, 17'h00004}, '{2, 17'h00006}, '{3, 17'h00008},
        '{4, 17'h0000A}, '{5, 17'h0000C}, '{6, 17'h0000E}, '{7, 17'h00010}, '{8, 17'h00012},
        '{9, 17'h00014}, '{10, 17'h00016}, '{11, 17'h00018}, '{12, 17'h0001A}, '{13, 17'h0001C},
        '{14, 17'h0001E}, '{15, 17'h00020}, '{16, 17'h00022}, '{17, 17'h00024}, '{18, 17'h00026},
        '{19, 17'h00028}, '{20, 17'h0002A}, '{21, 17'h0002C}, '{22, 17'h0002E}, '{23, 17'h00030},
        '{24, 17'h00032}, '{25, 17'h00034}, '{26, 17'h00036}, '{27, 17'h00038}, '{28, 17'h0003A},
        '{29, 17'h0003C}};
    logic clk_i = 0, rst_i = 1, fuse = 1, vsel = 0, go = 0, acc, pend, load, is_rst;
    logic [4:0] rsrc = 5'h00, num;
    logic [29:0] irq = 30'h00000000;
    logic [16:0] addr, boot = BOOT_ADDR;
    int err_total = 0, num_checks = 0;
    initial forever #20 clk_i = ~clk_i;
    ivam_top dut_u (.clk_i(clk_i), .rst_i(rst_i), .ext_pin_reset_i(rsrc[0]),
        .power_on_reset_i(rsrc[1]), .brown_out_reset_i(rsrc[2]), .watchdog_reset_i(rsrc[3]),
        .debug_reset_i(rsrc[4]), .boot_reset_fuse_i(fuse), .vector_select_bit_i(vsel),
        .boot_reset_addr_i(boot), .irq_req_i(irq), .int_accept_i(acc), .irq_pending_o(pend),
        .irq_vec_num_o(num), .pc_load_o(load), .pc_is_reset_o(is_rst), .pc_addr_o(addr));
    ivam_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .irq_pending_i(pend),
        .int_accept_o(acc));
    task automatic check(string n, logic [17:0] seen, logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic step(); @(posedge clk_i); #1; endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // raise a request, let the core take it, compare the entry address
    task automatic take(logic [29:0] r, logic [16:0] exp, string n);
        irq = r;
        go = 1;
        for (int i = 0; i < 8 && load !== 1'h1; i++) step();
        if (load !== 1'h1) begin
            err_total++;
            $display("[ERR] %s expected %h seen no load", n, exp);
            finish_test();
        end
        check(n, {load & ~is_rst, addr}, {1'h1, exp});
        go = 0;
        irq = 30'h00000000;
        repeat (2) step();
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        #1 rst_i = 0;
        step();
        check("reset start", {load & is_rst, addr}, {1'h1, 17'h00000});
        step();
        foreach (rows[i]) take(30'h1 << rows[i].b, rows[i].a, "vector");
        take(30'h00000220, 17'h0000C, "lowest wins");
        vsel = 1;
        take(30'h00000001, BOOT_ADDR + 17'h00002, "moved first");
        take(30'h20000000, BOOT_ADDR + 17'h0003C, "moved last");
        vsel = 0;
        $display("table and vector select done");
        for (int k = 0; k < 5; k++) begin
            rsrc = 5'h01 << k;
            step();
            rsrc = 5'h00;
            check("reset source", {load & is_rst, addr}, {1'h1, 17'h00000});
        end
        fuse = 0;
        boot = BOOT_ALT;
        rst_i = 1;
        step();
        rst_i = 0;
        step();
        check("boot reset", {load & is_rst, addr}, {1'h1, BOOT_ALT});
        rsrc = 5'h08;
        fuse = 1; // caught at release, so a live change must not move the entry
        step();
        rsrc = 5'h00;
        check("boot watchdog", {load & is_rst, addr}, {1'h1, BOOT_ALT});
        // a reset source in the accept cycle wins over the interrupt entry
        irq = 30'h00000004;
        go = 1;
        for (int i = 0; i < 8 && acc !== 1'h1; i++) step();
        check("accept and vector", {11'h000, acc, pend, num}, {11'h000, 2'h3, 5'h04});
        rsrc = 5'h10;
        step();
        rsrc = 5'h00;
        go = 0;
        irq = 30'h00000000;
        check("reset over entry", {load & is_rst, addr}, {1'h1, BOOT_ALT});
        repeat (2) step();
        take(30'h00000001, 17'h00002, "split sections");
        $display("reset placement done");
        finish_test();
    end
endmodule
`default_nettype wire
